// ### design/prio_bank_pkg.sv
// What this block does
// - each source has a three-bit level field and code 111 means level 7, the highest.
// - code 001 means level 1, the lowest enabled level, and codes between map linearly.
// - code 000 disables the source so it never requests service.
// - every unimplemented bit reads back as zero.
// - at reset every implemented field loads 100, level 4.
// - first register holds change notify 14-12, comparator 10-8, i2c master 6-4, slave 2-0.
// - second register holds capture 8 at 14-12, capture 7 at 10-8, 7-3 empty, ext irq 1 at 2-0.
// - third register holds timer 4 at 14-12, compare 4 at 10-8, compare 3 at 6-4, low nibble empty.
// - fourth register holds uart tx 14-12, uart rx 10-8, ext irq 2 at 6-4, timer 5 at 2-0.
// - fifth register has 15-7 empty, spi event at 6-4 and spi fault at 2-0.
// - sixth register holds capture 5 at 14-12, capture 4 at 10-8, capture 3 at 6-4.
// - separator bits 15, 11, 7 and 3 are unimplemented and ignore writes.
package prio_bank_pkg;

   // ****************************************
   // register map
   // ****************************************
   localparam int ADDR_WIDTH = 4;
   localparam int DATA_WIDTH = 16;
   localparam int LEVEL_WIDTH = 3;
   localparam logic [3:0] OFS_CN_CMP_I2C = 4'h0;
   localparam logic [3:0] OFS_CAP87_EXT1 = 4'h1;
   localparam logic [3:0] OFS_TMR4_CMP43 = 4'h2;
   localparam logic [3:0] OFS_UART_EXT2_TMR5 = 4'h3;
   localparam logic [3:0] OFS_SPI_EVT_FLT = 4'h4;
   localparam logic [3:0] OFS_CAP543 = 4'h5;

   // ****************************************
   // field layout: low bit of each 3-bit field
   // ****************************************
   localparam int POS_HI = 12;
   localparam int POS_MH = 8;
   localparam int POS_ML = 4;
   localparam int POS_LO = 0;

   // ****************************************
   // reset value and implemented-bit masks
   // ****************************************
   localparam logic [2:0] LEVEL_RESET = 3'h4;
   localparam logic [2:0] LEVEL_OFF = 3'h0;
   localparam logic [15:0] MASK_FULL = 16'h7777;
   localparam logic [15:0] MASK_CAP87_EXT1 = 16'h7707;
   localparam logic [15:0] MASK_NO_LOW = 16'h7770;
   localparam logic [15:0] MASK_LOW_TWO = 16'h0077;

endpackage : prio_bank_pkg

// ### design/prio_field.sv
`timescale 1ns/1ns
// one three-bit level field with reset to level 4
module prio_field (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic write_en,
   input wire logic [2:0] write_value,
   output logic [2:0] level
);

   // ****************************************
   // storage
   // ****************************************
   // load on write, level 4 at reset
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         level <= prio_bank_pkg::LEVEL_RESET;
      end else if (write_en) begin
         level <= write_value;
      end
   end

endmodule : prio_field

// ### design/prio_src_request.sv
`timescale 1ns/1ns
// gates a source request by its level; level 0 never requests
module prio_src_request (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic pending,
   input wire logic [2:0] level,
   output logic request
);

   // ****************************************
   // gated request
   // ****************************************
   // registered so the output is a flip-flop
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         request <= 1'b0;
      end else begin
         request <= pending && (level != prio_bank_pkg::LEVEL_OFF);
      end
   end

endmodule : prio_src_request

// ### design/interrupt_priority_bank.sv
// The register offsets and the plain strobed port were decided locally.
`timescale 1ns/1ns
// bank of six priority registers feeding the interrupt arbiter
module interrupt_priority_bank #(
   parameter int NUM_SRC = 19
) (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [15:0] reg_rdata,
   input wire logic [NUM_SRC-1:0] src_pending,
   output logic [NUM_SRC-1:0] src_request,
   output logic [3*NUM_SRC-1:0] src_level
);

   // ****************************************
   // source table
   // ****************************************
   // index order of sources in src_level and src_request:
   // 0 change_notify 1 comparator 2 i2c master 3 i2c slave
   // 4 capture 8 5 capture 7 6 ext irq 1
   // 7 timer 4 8 compare 4 9 compare 3
   // 10 uart tx 11 uart rx 12 ext irq 2 13 timer 5
   // 14 spi event 15 spi fault
   // 16 capture 5 17 capture 4 18 capture 3
   localparam int NUM_FIELDS = 19;

   // ****************************************
   // register layout
   // ****************************************
   // every implemented field is three bits wide and resets to level 4;
   // code 7 is the highest level, code 1 the lowest, code 0 mutes the source
   // offset 0, change notify and comparator and i2c one:
   //    14-12 change notify, 10-8 comparator
   //    6-4 i2c master, 2-0 i2c slave
   //    separators 15, 11, 7 and 3 read zero
   // offset 1, captures 8 and 7 and ext irq 1:
   //    14-12 capture 8, 10-8 capture 7
   //    2-0 ext irq 1
   //    15, 11 and 7-3 read zero
   // offset 2, timer 4 and compares 4 and 3:
   //    14-12 timer 4, 10-8 compare 4
   //    6-4 compare 3
   //    15, 11, 7 and 3-0 read zero
   // offset 3, uart two and ext irq 2 and timer 5:
   //    14-12 uart tx, 10-8 uart rx
   //    6-4 ext irq 2, 2-0 timer 5
   //    separators 15, 11, 7 and 3 read zero
   // offset 4, spi two event and fault:
   //    6-4 spi event, 2-0 spi fault
   //    15-7 and 3 read zero
   // offset 5, captures 5, 4 and 3:
   //    14-12 capture 5, 10-8 capture 4
   //    6-4 capture 3
   //    15, 11, 7 and 3-0 read zero
   // offsets 6 to 15 hold nothing: writes vanish, reads give zero
   // a write replaces all fields of its register at once

   // register offset per source
   function automatic logic [3:0] src_ofs(input int idx);
      logic [3:0] ofs;
      ofs = prio_bank_pkg::OFS_CN_CMP_I2C;
      if (idx >= 16) begin
         ofs = prio_bank_pkg::OFS_CAP543;
      end else if (idx >= 14) begin
         ofs = prio_bank_pkg::OFS_SPI_EVT_FLT;
      end else if (idx >= 10) begin
         ofs = prio_bank_pkg::OFS_UART_EXT2_TMR5;
      end else if (idx >= 7) begin
         ofs = prio_bank_pkg::OFS_TMR4_CMP43;
      end else if (idx >= 4) begin
         ofs = prio_bank_pkg::OFS_CAP87_EXT1;
      end
      return ofs;
   endfunction : src_ofs

   // low bit position of each source field
   function automatic int src_pos(input int idx);
      int pos;
      pos = prio_bank_pkg::POS_HI;
      case (idx)
         0, 4, 7, 10, 16: pos = prio_bank_pkg::POS_HI;
         1, 5, 8, 11, 17: pos = prio_bank_pkg::POS_MH;
         2, 9, 12, 14, 18: pos = prio_bank_pkg::POS_ML;
         3, 6, 13, 15: pos = prio_bank_pkg::POS_LO;
         default: pos = prio_bank_pkg::POS_HI;
      endcase
      return pos;
   endfunction : src_pos

   // ****************************************
   // field storage
   // ****************************************
   logic [2:0] level_q [NUM_FIELDS];

   // one field instance per source, placed at its documented bits
   for (genvar g = 0; g < NUM_FIELDS; g++) begin : g_field
      logic hit;
      assign hit = reg_write && (reg_addr == src_ofs(g));
      prio_field u_field (
         .clk_sys(clk_sys),
         .reset_n(reset_n),
         .write_en(hit),
         .write_value(reg_wdata[src_pos(g) +: 3]),
         .level(level_q[g])
      );
      assign src_level[3*g +: 3] = level_q[g];
      prio_src_request u_req (
         .clk_sys(clk_sys),
         .reset_n(reset_n),
         .pending(src_pending[g]),
         .level(level_q[g]),
         .request(src_request[g])
      );
   end

   // ****************************************
   // read path
   // ****************************************
   logic [15:0] read_next;

   // assemble the addressed word; empty and separator bits stay zero
   always_comb begin
      read_next = 16'h0000;
      for (int i = 0; i < NUM_FIELDS; i++) begin
         if (reg_addr == src_ofs(i)) begin
            read_next[src_pos(i) +: 3] = level_q[i];
         end
      end
   end

   // the master never waits: the word is taken from the fields in the strobe
   // cycle and stands on reg_rdata for exactly the next cycle, so a read right
   // after a write already returns the new value
   // between reads the port idles at zero
   // read data valid the cycle after the strobe, else zero
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         reg_rdata <= 16'h0000;
      end else if (reg_read) begin
         reg_rdata <= read_next;
      end else begin
         reg_rdata <= 16'h0000;
      end
   end

   // ****************************************
   // checks
   // ****************************************
   // implemented bits of the addressed register, zero for empty offsets
   logic [15:0] impl_mask;
   always_comb begin
      case (reg_addr)
         prio_bank_pkg::OFS_CN_CMP_I2C: impl_mask = prio_bank_pkg::MASK_FULL;
         prio_bank_pkg::OFS_CAP87_EXT1: impl_mask = prio_bank_pkg::MASK_CAP87_EXT1;
         prio_bank_pkg::OFS_TMR4_CMP43: impl_mask = prio_bank_pkg::MASK_NO_LOW;
         prio_bank_pkg::OFS_UART_EXT2_TMR5: impl_mask = prio_bank_pkg::MASK_FULL;
         prio_bank_pkg::OFS_SPI_EVT_FLT: impl_mask = prio_bank_pkg::MASK_LOW_TWO;
         prio_bank_pkg::OFS_CAP543: impl_mask = prio_bank_pkg::MASK_NO_LOW;
         default: impl_mask = 16'h0000;
      endcase
   end

   // expected value of each request flop for the next edge
   logic [NUM_SRC-1:0] request_expect;
   always_comb begin
      request_expect = '0;
      for (int i = 0; i < NUM_FIELDS; i++) begin
         request_expect[i] = src_pending[i] && (level_q[i] != prio_bank_pkg::LEVEL_OFF);
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);

   // ****************************************
   // read path checks
   // ****************************************
   // empty bits never read as one
   chk_unimpl_reads_zero: assert property (
      reg_read |=> (reg_rdata & ~$past(impl_mask)) == 16'h0000)
      else $error("unimplemented bit read as one");

   // a write read back at once returns only the implemented bits
   chk_write_readback: assert property (
      reg_write ##1 (reg_read && reg_addr == $past(reg_addr))
      |=> reg_rdata == ($past(reg_wdata, 2) & $past(impl_mask, 2)))
      else $error("readback differs from masked write");

   // read data drops back to zero when no read was strobed
   chk_rdata_idle: assert property (
      !reg_read |=> reg_rdata == 16'h0000)
      else $error("read data stood without a read");

   // read data carries the stored levels of the strobe cycle
   chk_rdata_first_word: assert property (
      reg_read && reg_addr == prio_bank_pkg::OFS_CN_CMP_I2C
      |=> reg_rdata[14:12] == $past(src_level[2:0])
      && reg_rdata[2:0] == $past(src_level[11:9]))
      else $error("first register read differs from levels");

   chk_rdata_tmr_word: assert property (
      reg_read && reg_addr == prio_bank_pkg::OFS_TMR4_CMP43
      |=> reg_rdata[14:12] == $past(src_level[23:21])
      && reg_rdata[6:4] == $past(src_level[29:27]))
      else $error("third register read differs from levels");

   chk_rdata_spi_word: assert property (
      reg_read && reg_addr == prio_bank_pkg::OFS_SPI_EVT_FLT
      |=> reg_rdata[6:4] == $past(src_level[44:42])
      && reg_rdata[2:0] == $past(src_level[47:45]))
      else $error("fifth register read differs from levels");

   // ****************************************
   // field placement checks
   // ****************************************
   // every write lands in the bits of its fields
   chk_cn_field_pos: assert property (
      reg_write && reg_addr == prio_bank_pkg::OFS_CN_CMP_I2C
      |=> src_level[2:0] == $past(reg_wdata[14:12]) && src_level[11:9] == $past(reg_wdata[2:0]))
      else $error("first register field placement wrong");

   chk_ext1_field_pos: assert property (
      reg_write && reg_addr == prio_bank_pkg::OFS_CAP87_EXT1
      |=> src_level[20:18] == $past(reg_wdata[2:0]) && src_level[14:12] == $past(reg_wdata[14:12]))
      else $error("second register field placement wrong");

   chk_cmp3_field_pos: assert property (
      reg_write && reg_addr == prio_bank_pkg::OFS_TMR4_CMP43
      |=> src_level[29:27] == $past(reg_wdata[6:4]))
      else $error("compare 3 field placement wrong");

   chk_tmr5_field_pos: assert property (
      reg_write && reg_addr == prio_bank_pkg::OFS_UART_EXT2_TMR5
      |=> src_level[41:39] == $past(reg_wdata[2:0]) && src_level[38:36] == $past(reg_wdata[6:4]))
      else $error("fourth register field placement wrong");

   chk_spi_field_pos: assert property (
      reg_write && reg_addr == prio_bank_pkg::OFS_SPI_EVT_FLT
      |=> src_level[47:45] == $past(reg_wdata[2:0]) && src_level[44:42] == $past(reg_wdata[6:4]))
      else $error("fifth register field placement wrong");

   chk_cap3_field_pos: assert property (
      reg_write && reg_addr == prio_bank_pkg::OFS_CAP543
      |=> src_level[56:54] == $past(reg_wdata[6:4]) && src_level[50:48] == $past(reg_wdata[14:12]))
      else $error("sixth register field placement wrong");

   // the fields not tested above, one register at a time
   chk_cmp_field_pos: assert property (
      reg_write && reg_addr == prio_bank_pkg::OFS_CN_CMP_I2C
      |=> src_level[5:3] == $past(reg_wdata[10:8]) && src_level[8:6] == $past(reg_wdata[6:4]))
      else $error("comparator or i2c master field placement wrong");

   chk_cap7_field_pos: assert property (
      reg_write && reg_addr == prio_bank_pkg::OFS_CAP87_EXT1
      |=> src_level[17:15] == $past(reg_wdata[10:8]))
      else $error("capture 7 field placement wrong");

   chk_tmr4_field_pos: assert property (
      reg_write && reg_addr == prio_bank_pkg::OFS_TMR4_CMP43
      |=> src_level[23:21] == $past(reg_wdata[14:12])
      && src_level[26:24] == $past(reg_wdata[10:8]))
      else $error("timer 4 or compare 4 field placement wrong");

   chk_uart_field_pos: assert property (
      reg_write && reg_addr == prio_bank_pkg::OFS_UART_EXT2_TMR5
      |=> src_level[32:30] == $past(reg_wdata[14:12])
      && src_level[35:33] == $past(reg_wdata[10:8]))
      else $error("uart field placement wrong");

   chk_cap4_field_pos: assert property (
      reg_write && reg_addr == prio_bank_pkg::OFS_CAP543
      |=> src_level[53:51] == $past(reg_wdata[10:8]))
      else $error("capture 4 field placement wrong");

   // a write leaves the fields of the other registers alone
   chk_first_write_local: assert property (
      reg_write && reg_addr == prio_bank_pkg::OFS_CN_CMP_I2C |=> $stable(src_level[56:12]))
      else $error("first register write disturbed other fields");

   chk_spi_write_local: assert property (
      reg_write && reg_addr == prio_bank_pkg::OFS_SPI_EVT_FLT
      |=> $stable(src_level[41:0]) && $stable(src_level[56:48]))
      else $error("fifth register write disturbed other fields");

   // a write to an empty offset changes nothing
   chk_unmapped_ignored: assert property (
      reg_write && impl_mask == 16'h0000 |=> $stable(src_level))
      else $error("write to an empty offset changed a level");

   // ****************************************
   // request and level checks
   // ****************************************
   // a source at code 0 never requests
   chk_level_zero_mutes: assert property (
      src_level[2:0] == 3'h0 |=> !src_request[0])
      else $error("disabled source still requests");

   // levels move only on a write
   chk_level_holds: assert property (
      !reg_write |=> $stable(src_level))
      else $error("levels changed without a write");

   // a pending source at code 7 requests
   chk_enabled_requests: assert property (
      src_pending[0] && src_level[2:0] == 3'h7 |=> src_request[0])
      else $error("level 7 source did not request");

   // a pending source at code 1 still requests
   chk_level_one_requests: assert property (
      src_pending[3] && src_level[11:9] == 3'h1 |=> src_request[3])
      else $error("level 1 source did not request");

   // every request flop follows its pending input and its level
   chk_request_all: assert property (
      reset_n |=> src_request == $past(request_expect))
      else $error("request vector differs from pending and levels");

   // ****************************************
   // reset checks
   // ****************************************
   // every field starts at level 4 when reset lets go
   chk_reset_levels: assert property (
      $rose(reset_n) |-> src_level == {NUM_FIELDS{prio_bank_pkg::LEVEL_RESET}})
      else $error("level not 4 after reset");

   // no read data and no request straight out of reset
   chk_reset_outputs: assert property (
      $rose(reset_n) |-> reg_rdata == 16'h0000 && src_request == '0)
      else $error("outputs not cleared by reset");

   // ****************************************
   // main scenarios
   // ****************************************
   // top level, muted source, back to back access, lowest level, live request
   cov_write_top: cover property (reg_write && reg_wdata[14:12] == 3'h7);
   cov_disable: cover property (reg_write && reg_wdata[2:0] == 3'h0);
   cov_read_after_write: cover property (reg_write ##1 reg_read);
   cov_level_one: cover property (src_level[2:0] == 3'h1);
   cov_top_request: cover property (src_request[0] && src_level[2:0] == 3'h7);

endmodule : interrupt_priority_bank

// ### verification/interrupt_priority_bank_test.sv
`timescale 1ns/1ns
module interrupt_priority_bank_test;
   // ***********************
   // signals and tables
   // ***********************
   logic clk_sys;
   logic reset_n;
   logic [3:0] reg_addr;
   logic [15:0] reg_wdata;
   logic reg_write;
   logic reg_read;
   logic [15:0] reg_rdata;
   logic [18:0] src_pending;
   logic [18:0] src_request;
   logic [56:0] src_level;
   int errors;
   int check_count;
   logic [15:0] words [6];
   localparam int src_ofs [19] = '{0, 0, 0, 0, 1, 1, 1, 2, 2, 2, 3, 3, 3, 3, 4, 4, 5, 5, 5};
   localparam int src_pos [19] = '{12, 8, 4, 0, 12, 8, 0, 12, 8, 4, 12, 8, 4, 0, 4, 0, 12, 8, 4};
   localparam logic [15:0] masks [6] = '{prio_bank_pkg::MASK_FULL,
      prio_bank_pkg::MASK_CAP87_EXT1, prio_bank_pkg::MASK_NO_LOW, prio_bank_pkg::MASK_FULL,
      prio_bank_pkg::MASK_LOW_TWO, prio_bank_pkg::MASK_NO_LOW};

   interrupt_priority_bank #(.NUM_SRC(19)) u_dut (
      .clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
      .src_pending(src_pending), .src_request(src_request), .src_level(src_level));

   // clock at 8 ns
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   // ***********************
   // shared tasks
   // ***********************
   task automatic compare(input logic [15:0] got, input logic [15:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask : compare

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_write <= 1'b0;
      #1;
   endtask : wr

   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, input logic [15:0] exp);
      @(posedge clk_sys);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_read <= 1'b0;
      #1 compare(reg_rdata, exp, "read data");
      @(posedge clk_sys);
      #1 compare(reg_rdata, 16'h0000, "read data after");
   endtask : rd

   // write then read back with no idle cycle between the strobes
   task automatic wr_rd(input logic [3:0] a, input logic [15:0] d, input logic [15:0] exp);
      @(posedge clk_sys);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_write <= 1'b0;
      reg_read <= 1'b1;
      @(posedge clk_sys);
      reg_read <= 1'b0;
      #1 compare(reg_rdata, exp, "readback");
      @(posedge clk_sys);
      #1 compare(reg_rdata, 16'h0000, "readback after");
   endtask : wr_rd

   task automatic chk_levels();
      for (int i = 0; i < 19; i++) begin
         compare({13'h0000, src_level[3*i +: 3]}, {13'h0000, words[src_ofs[i]][src_pos[i] +: 3]},
            "source level");
      end
   endtask : chk_levels

   // ***********************
   // scenarios
   // ***********************
   task automatic test_reset();
      for (int r = 0; r < 6; r++) begin
         words[r] = 16'h4444 & masks[r];
         rd(r[3:0], words[r]);
      end
      chk_levels();
   endtask : test_reset

   task automatic test_disable();
      @(posedge clk_sys);
      src_pending <= '1;
      wr(4'h0, 16'h0001);
      compare({13'h0000, src_level[11:9]}, 16'h0001, "level next cycle");
      repeat (2) @(posedge clk_sys);
      #1 compare(src_request[15:0], 16'hfff8, "requests off");
      compare({13'h0000, src_request[18:16]}, 16'h0007, "upper requests");
      wr(4'h0, 16'h7777);
      repeat (2) @(posedge clk_sys);
      #1 compare(src_request[15:0], 16'hffff, "requests on");
      @(posedge clk_sys);
      src_pending <= '0;
   endtask : test_disable

   task automatic test_max();
      for (int r = 0; r < 6; r++) begin
         words[r] = masks[r];
         wr(r[3:0], 16'hffff);
         rd(r[3:0], masks[r]);
      end
      chk_levels();
   endtask : test_max

   // separator bits are set and must not stick
   task automatic test_layout();
      for (int r = 0; r < 6; r++) begin
         words[r] = 16'h1235 & masks[r];
         wr_rd(r[3:0], 16'h9abd, words[r]);
      end
      chk_levels();
   endtask : test_layout

   task automatic test_unmapped();
      wr(4'h6, 16'hffff);
      wr(4'hf, 16'hffff);
      rd(4'h6, 16'h0000);
      rd(4'hf, 16'h0000);
      rd(4'h0, words[0]);
   endtask : test_unmapped

   // reset in mid-run after writes brings every field back to level 4
   task automatic test_rereset();
      @(posedge clk_sys);
      reset_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      reset_n <= 1'b1;
      test_reset();
   endtask : test_rereset

   task automatic give_verdict();
      $display("errors %0d checks %0d", errors, check_count);
      if (errors == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : give_verdict

   // main sequence
   initial begin
      errors = 0;
      check_count = 0;
      reset_n = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 16'h0000;
      reg_write = 1'b0;
      reg_read = 1'b0;
      src_pending = '0;
      repeat (12) @(posedge clk_sys);
      reset_n <= 1'b1;
      test_reset();
      test_disable();
      test_max();
      test_layout();
      test_unmapped();
      test_rereset();
      give_verdict();
   end

   // watchdog well beyond the roughly 130 cycles needed
   initial begin
      #200000;
      errors++;
      give_verdict();
   end
endmodule : interrupt_priority_bank_test
